// file: hdl/e1rcb_consts.svh
// offsets, field positions, reset values and timing counts of the receive signaling buffer
`ifndef E1RCB_CONSTS_SVH
`define E1RCB_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define E1RCB_IDX_CONFIG     12'h0D2
`define E1RCB_IDX_ACC_STAT   12'h0D3
`define E1RCB_IDX_ACC_CTRL   12'h0D4
`define E1RCB_IDX_ACC_DATA   12'h0D5
`define E1RCB_IDX_FLAGS0     12'h0D6
`define E1RCB_IDX_FLAGS1     12'h0D7
`define E1RCB_IDX_FLAGS2     12'h0D8
`define E1RCB_IDX_FLAGS3     12'h0D9
`define E1RCB_IDX_INT_STAT   12'h0DA
`define E1RCB_IDX_INT_MASK   12'h0DB

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define E1RCB_CFG_DEBOUNCE   0
`define E1RCB_CFG_HOLD       1
`define E1RCB_CFG_IRQ_EN     2
`define E1RCB_CFG_SIXTEEN    3
`define E1RCB_CTRL_RNW       7
`define E1RCB_STAT_BUSY      0
`define E1RCB_IND_EXTRACT    4
`define E1RCB_EV_CHANGE      0
`define E1RCB_EV_SLIP        1
`define E1RCB_EV_ACC_DONE    2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define E1RCB_CONFIG_RST     8'h00
`define E1RCB_CTRL_RST       8'h00
`define E1RCB_MASK_RST       8'h00
`define E1RCB_ACC_CYCLES     2

`endif

// file: hdl/e1rcb_pkg.sv
// types shared by the receive signaling buffer
package e1rcb_pkg;

  // one timeslot-16 byte from the framer, with its frame number in the multiframe
  typedef struct packed {
    logic       valid;
    logic [3:0] frame;
    logic [7:0] octet;
  } e1rcb_ts16_s;

  // alignment and slip state from the framer and elastic store
  typedef struct packed {
    logic out_of_frame;
    logic out_of_mframe;
    logic slip;
  } e1rcb_alarm_s;

  // system-side bit position and data bit
  typedef struct packed {
    logic       strobe;
    logic [4:0] ts;
    logic [2:0] bit_pos;
    logic       data;
  } e1rcb_sys_s;

  typedef logic [3:0] e1rcb_abcd_t;

endpackage

// file: hdl/e1rcb_top.sv
// receive CAS signaling buffer for one E1 link, with an AHB-Lite register slave
`timescale 1ns/1ps
`include "e1rcb_consts.svh"

module e1rcb_top #(
  parameter int ACC_CYCLES = `E1RCB_ACC_CYCLES
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire e1rcb_pkg::e1rcb_ts16_s  ts16_in,
  input  wire e1rcb_pkg::e1rcb_alarm_s alarm_in,
  input  wire e1rcb_pkg::e1rcb_sys_s   sys_in,
  output logic                       rx_data_out,
  output logic                       rx_signaling_out,
  output logic                       irq_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // timeslot 1..15 -> flag bit 0..14, 17..31 -> 15..29
  function automatic logic [29:0] flag_bit(input logic [4:0] ts);
    logic [29:0] r;
    logic [4:0]  i;
    r = 30'h0;
    i = (ts < 5'd16) ? ts - 5'd1 : ts - 5'd2;
    if (ts != 5'd0 && ts != 5'd16)
      r[i] = 1'b1;
    return r;
  endfunction

  function automatic logic slot_ok(input logic [6:0] a);
    return (a[6:5] == 2'b00) && (a[3:0] != 4'h0);
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  e1rcb_pkg::e1rcb_abcd_t abcd_q [0:31];
  e1rcb_pkg::e1rcb_abcd_t last_q [0:31];
  logic                   ext_q  [0:31];
  logic [29:0]            flags_q;
  logic [7:0]             cfg_q;
  logic [7:0]             ctrl_q;
  logic [7:0]             data_q;
  logic [7:0]             ist_q;
  logic [7:0]             imask_q;
  logic                   busy_q;
  logic [7:0]             acc_cnt_q;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [11:0] idx_q;
  logic        ready_q;
  logic [31:0] rdata_q;
  logic        resp_q;
  logic        take_xfer;
  logic        wr_now;
  logic        rd_now;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;

  assign take_xfer = hsel && htrans[1] && hready && ready_q;
  assign wr_now    = wr_pend_q;
  assign rd_now    = rd_pend_q;
  assign wbyte     = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 12'h000;
      ready_q   <= 1'b1;
      resp_q    <= 1'b0;
    end
    else if (ce)
    begin
      wr_pend_q <= take_xfer && hwrite;
      rd_pend_q <= take_xfer && !hwrite;
      if (take_xfer)
        idx_q <= haddr[13:2];
      // reads insert one wait state so data reflects a write just before
      if (take_xfer && !hwrite)
        ready_q <= 1'b0;
      else
        ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  always_comb
  begin
    rbyte = 8'h00;
    unique case (idx_q)
      `E1RCB_IDX_CONFIG:   rbyte = cfg_q;
      `E1RCB_IDX_ACC_STAT: rbyte = {7'h00, busy_q};
      `E1RCB_IDX_ACC_CTRL: rbyte = ctrl_q;
      `E1RCB_IDX_ACC_DATA: rbyte = data_q;
      `E1RCB_IDX_FLAGS0:   rbyte = flags_q[7:0];
      `E1RCB_IDX_FLAGS1:   rbyte = flags_q[15:8];
      `E1RCB_IDX_FLAGS2:   rbyte = flags_q[23:16];
      `E1RCB_IDX_FLAGS3:   rbyte = {2'b00, flags_q[29:24]};
      `E1RCB_IDX_INT_STAT: rbyte = ist_q;
      `E1RCB_IDX_INT_MASK: rbyte = imask_q;
      default:             rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_q <= 32'h0000_0000;
    else if (ce && rd_now)
      rdata_q <= {24'h000000, rbyte};
  end

  // ----------------------------------------------------------------
  // configuration and mask
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q   <= `E1RCB_CONFIG_RST;
      imask_q <= `E1RCB_MASK_RST;
    end
    else if (ce && wr_now)
    begin
      if (idx_q == `E1RCB_IDX_CONFIG)
        cfg_q <= {4'h0, wbyte[3:0]};
      if (idx_q == `E1RCB_IDX_INT_MASK)
        imask_q <= {5'h00, wbyte[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // indirect access engine
  // ----------------------------------------------------------------
  logic       start_acc;
  logic       acc_done;
  logic [6:0] acc_addr;
  logic       acc_rnw;

  // address field of the control register picks the target
  assign acc_addr  = ctrl_q[6:0];
  assign acc_rnw   = ctrl_q[`E1RCB_CTRL_RNW];
  assign start_acc = wr_now && (idx_q == `E1RCB_IDX_ACC_CTRL) && !busy_q;
  assign acc_done  = busy_q && (acc_cnt_q == 8'd1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q    <= `E1RCB_CTRL_RST;
      busy_q    <= 1'b0;
      acc_cnt_q <= 8'h00;
    end
    else if (ce)
    begin
      // busy held for the whole access
      if (start_acc)
      begin
        ctrl_q    <= wbyte;
        busy_q    <= 1'b1;
        acc_cnt_q <= ACC_CYCLES[7:0];
      end
      else if (busy_q)
      begin
        acc_cnt_q <= acc_cnt_q - 8'd1;
        if (acc_done)
          busy_q <= 1'b0;
      end
    end
  end

  // data register: host writes only while idle; a read access loads it at the end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      data_q <= 8'h00;
    else if (ce)
    begin
      // only the addresses of timeslots 1 to 15 and 17 to 31 return content
      if (acc_done && acc_rnw)
        data_q <= slot_ok(acc_addr) ?
                  {3'b000, ext_q[acc_addr[4:0]], abcd_q[acc_addr[4:0]]} : 8'h00;
      else if (wr_now && idx_q == `E1RCB_IDX_ACC_DATA && !busy_q)
        data_q <= wbyte;
    end
  end

  logic host_wr_slot;
  assign host_wr_slot = acc_done && !acc_rnw && slot_ok(acc_addr);

  // ----------------------------------------------------------------
  // extraction from timeslot 16
  // ----------------------------------------------------------------
  logic        frozen;
  logic        take_byte;
  logic [4:0]  sl    [0:1];
  logic [3:0]  nib   [0:1];
  logic        upd   [0:1];
  logic        chg   [0:1];
  logic [29:0] set_flags;

  // alignment loss or slip freezes updating
  assign frozen = alarm_in.out_of_frame || alarm_in.out_of_mframe || alarm_in.slip ||
                  cfg_q[`E1RCB_CFG_HOLD];
  // frame 0 of the multiframe carries the alignment word, not signaling
  assign take_byte = ts16_in.valid && (ts16_in.frame != 4'h0) && !frozen;

  always_comb
  begin
    set_flags = 30'h0;
    sl[0]  = {1'b0, ts16_in.frame};
    sl[1]  = {1'b1, ts16_in.frame};
    nib[0] = ts16_in.octet[7:4];
    nib[1] = ts16_in.octet[3:0];
    for (int k = 0; k < 2; k++)
    begin
      // debounce needs a repeat of the previous codeword
      upd[k] = take_byte && ext_q[sl[k]] &&
               (!cfg_q[`E1RCB_CFG_DEBOUNCE] || nib[k] == last_q[sl[k]]);
      chg[k] = upd[k] && (nib[k] != abcd_q[sl[k]]);
      if (chg[k])
        set_flags = set_flags | flag_bit(sl[k]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        abcd_q[i] <= 4'h0;
        last_q[i] <= 4'h0;
        ext_q[i]  <= 1'b0;
      end
    end
    else if (ce)
    begin
      if (host_wr_slot)
      begin
        abcd_q[acc_addr[4:0]] <= data_q[3:0];
        ext_q[acc_addr[4:0]]  <= data_q[`E1RCB_IND_EXTRACT];
      end
      // history kept only while not frozen, so debounce restarts cleanly
      if (take_byte)
      begin
        last_q[sl[0]] <= nib[0];
        last_q[sl[1]] <= nib[1];
      end
      // extracted codes win over a simultaneous host write of the same slot
      for (int k = 0; k < 2; k++)
        if (upd[k])
          abcd_q[sl[k]] <= nib[k];
    end
  end

  // ----------------------------------------------------------------
  // change flags and interrupt status, clear on read, set wins
  // ----------------------------------------------------------------
  logic [29:0] rd_clr;
  logic [7:0]  ev;

  always_comb
  begin
    rd_clr = 30'h0;
    if (rd_now)
    begin
      unique case (idx_q)
        `E1RCB_IDX_FLAGS0: rd_clr[7:0]   = 8'hFF;
        `E1RCB_IDX_FLAGS1: rd_clr[15:8]  = 8'hFF;
        `E1RCB_IDX_FLAGS2: rd_clr[23:16] = 8'hFF;
        `E1RCB_IDX_FLAGS3: rd_clr[29:24] = 6'h3F;
        default:           rd_clr        = 30'h0;
      endcase
    end
    ev = 8'h00;
    ev[`E1RCB_EV_CHANGE]   = |set_flags;
    ev[`E1RCB_EV_SLIP]     = alarm_in.slip;
    ev[`E1RCB_EV_ACC_DONE] = acc_done;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags_q <= 30'h0;
      ist_q   <= 8'h00;
    end
    else if (ce)
    begin
      // change of stored code sets its flag
      flags_q <= (flags_q & ~rd_clr) | set_flags;
      if (rd_now && idx_q == `E1RCB_IDX_INT_STAT)
        ist_q <= ev;
      else
        ist_q <= ist_q | ev;
    end
  end

  // ----------------------------------------------------------------
  // system-side outputs
  // ----------------------------------------------------------------
  logic [3:0] cur_abcd;
  logic [2:0] nib_sel;

  assign cur_abcd = abcd_q[sys_in.ts];
  assign nib_sel  = 3'd7 - sys_in.bit_pos;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_data_out      <= 1'b0;
      rx_signaling_out <= 1'b0;
      irq_n            <= 1'b1;
    end
    else if (ce)
    begin
      // data and signaling share one register stage to stay aligned
      if (sys_in.strobe)
      begin
        rx_data_out <= sys_in.data;
        // stored code drives the lower nibble
        // timeslots 0 and 16 simply show their unused entries
        rx_signaling_out <= sys_in.bit_pos[2] ? cur_abcd[nib_sel[1:0]] : 1'b0;
      end
      // change flags reach the pin when enabled
      irq_n <= !((cfg_q[`E1RCB_CFG_IRQ_EN] && |flags_q) || |(ist_q & imask_q));
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = ready_q;
  assign hresp     = resp_q;

endmodule

// file: tb/e1rcb_assertions.sv
// port assertions of the receive signaling buffer
`timescale 1ns/1ps
module e1rcb_checker (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    ce,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire e1rcb_pkg::e1rcb_ts16_s  ts16_in,
  input wire e1rcb_pkg::e1rcb_alarm_s alarm_in,
  input wire e1rcb_pkg::e1rcb_sys_s   sys_in,
  input wire logic                    rx_data_out,
  input wire logic                    rx_signaling_out,
  input wire logic                    irq_n
);
  logic tk;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  assign tk = hsel & htrans[1] & hready & hreadyout & ce;

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("error response");
  read_wait_a: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_wait_a: assert property (tk && hwrite |=> hreadyout)
    else $error("write stretched");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  data_align_a: assert property (
    sys_in.strobe && ce |=> rx_data_out == $past(sys_in.data))
    else $error("data bit misaligned");
  nibble_low_a: assert property (
    sys_in.strobe && ce && !sys_in.bit_pos[2] |=> !rx_signaling_out)
    else $error("signaling outside lower nibble");
  ce_hold_a: assert property (!ce |=> $stable(rx_signaling_out) && $stable(irq_n))
    else $error("state moved with enable low");
  // irq_n answers two edges after the byte; slip is left out since it may raise an unmasked event
  freeze_irq_a: assert property (
    ts16_in.valid && (alarm_in.out_of_frame || alarm_in.out_of_mframe) && irq_n
    ##1 irq_n |=> irq_n)
    else $error("update during alarm");
  rd_cov: cover property (tk && !hwrite);
  irq_cov: cover property ($fell(irq_n));
  sig_cov: cover property (sys_in.strobe && sys_in.bit_pos == 3'h4);
endmodule

bind e1rcb_top e1rcb_checker i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .ts16_in(ts16_in), .alarm_in(alarm_in), .sys_in(sys_in),
  .rx_data_out(rx_data_out), .rx_signaling_out(rx_signaling_out), .irq_n(irq_n));

// file: tb/e1rcb_sys_model.sv
// system backplane model: walks the timeslot grid and gathers signaling nibbles
`timescale 1ns/1ps
module e1rcb_sys_model (
  input  wire logic             hclk,
  output e1rcb_pkg::e1rcb_sys_s sys_o,
  input  wire logic             rx_data_out,
  input  wire logic             rx_signaling_out
);
  logic [3:0] sig [32];
  int         bad;
  logic       d;

  initial
  begin
    sys_o = '0;
    bad = 0;
  end

  // data flips between strobes so a stale bit cannot pass
  task automatic frame();
    for (int t = 0; t < 32; t++)
      for (int b = 0; b < 8; b++)
      begin
        d = t[b % 5] ^ b[0];
        @(posedge hclk);
        sys_o <= {1'b1, 5'(t), 3'(b), d};
        @(posedge hclk);
        sys_o <= {1'b0, 5'(t), 3'(b), ~d};
        #1;
        // data and nibble share the slot
        if (rx_data_out !== d)
          bad++;
        if (b > 3)
          sig[t][7 - b] = rx_signaling_out;
      end
  endtask
endmodule

// file: tb/e1rcb_top_tb.sv
// self-checking bench of the receive signaling buffer
`timescale 1ns/1ps
`include "e1rcb_consts.svh"
module e1rcb_top_tb;
  logic        hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic        rx_data_out, rx_signaling_out, irq_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, fl;
  logic [7:0]  cfg, rd, oc;
  logic [3:0]  fr;
  logic [3:0]  st [32];
  logic [3:0]  pv [32];
  logic        ex [32];
  logic [10:0] ph [7];
  int          num_errors, cmp_count, cyc, seed;
  e1rcb_pkg::e1rcb_ts16_s  ts16_in;
  e1rcb_pkg::e1rcb_alarm_s alarm_in;
  e1rcb_pkg::e1rcb_sys_s   sys_in;

  assign hready = hreadyout;
  always #25 hclk = ~hclk;

  // a long access lets the first status poll see busy
  e1rcb_top #(.ACC_CYCLES(6)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ts16_in(ts16_in), .alarm_in(alarm_in), .sys_in(sys_in), .rx_data_out(rx_data_out),
    .rx_signaling_out(rx_signaling_out), .irq_n(irq_n));
  e1rcb_sys_model i_sys (.hclk(hclk), .sys_o(sys_in), .rx_data_out(rx_data_out),
    .rx_signaling_out(rx_signaling_out));

  task automatic summarize();
    $display("%0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_reg({7'h0, got}, {7'h0, exp});
  endtask

  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {18'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask

  task automatic ind(input logic rnw, input logic [6:0] a, input logic [7:0] d);
    if (!rnw)
      bus(1'b1, `E1RCB_IDX_ACC_DATA, d);
    bus(1'b1, `E1RCB_IDX_ACC_CTRL, {rnw, a});
    bus(1'b0, `E1RCB_IDX_ACC_STAT, 8'h00);
    cmp_reg(rd, 8'h01);
    while (rd[0] !== 1'b0)
      bus(1'b0, `E1RCB_IDX_ACC_STAT, 8'h00);
    if (rnw)
      bus(1'b0, `E1RCB_IDX_ACC_DATA, 8'h00);
  endtask

  task automatic inject(input logic [3:0] f, input logic [7:0] o);
    logic       frz;
    logic [3:0] n;
    int         t;
    @(posedge hclk);
    ts16_in <= {1'b1, f, o};
    frz = cfg[1] | (|alarm_in);
    @(posedge hclk);
    ts16_in <= {1'b0, ~f, ~o};
    for (int k = 0; k < 2; k++)
    begin
      t = f + 16 * k;
      n = k ? o[3:0] : o[7:4];
      // frame zero and frozen slots stay put
      if (f != 0 && !frz)
      begin
        if (ex[t] && (!cfg[0] || pv[t] == n) && st[t] != n)
        begin
          st[t] = n;
          fl[t < 16 ? t - 1 : t - 2] = 1'b1;
        end
        pv[t] = n;
      end
    end
  endtask

  task automatic check_all();
    int t;
    repeat (2) @(posedge hclk);
    cmp_bit(irq_n, !(cfg[2] && fl != 0));
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, `E1RCB_IDX_FLAGS0 + 12'(i), 8'h00);
      cmp_reg(rd, fl[8*i +: 8]);
    end
    fl = '0;
    i_sys.frame();
    cmp_reg(8'(i_sys.bad), 8'h00);
    for (t = 1; t < 32; t++)
      if (t != 16)
        cmp_reg({4'h0, i_sys.sig[t]}, {4'h0, st[t]});
    t = 17 + {$random(seed)} % 15;
    ind(1'b1, 7'(t), 8'h00);
    cmp_reg(rd, {3'h0, ex[t], st[t]});
  endtask

  initial
  begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    ce = 1'b1;
    hsize = 3'b010;
    ts16_in = '0;
    alarm_in = '0;
    {num_errors, cmp_count, cyc} = '0;
    seed = 55586;
    fl = '0;
    // last phase keeps the change interrupt disabled while flags are set
    ph = '{11'h004, 11'h005, 11'h006, 11'h404, 11'h204, 11'h104, 11'h001};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, `E1RCB_IDX_FLAGS0, 8'hFF);
    for (int i = 0; i < 11; i++)
    begin
      bus(1'b0, i < 10 ? `E1RCB_IDX_CONFIG + 12'(i) : 12'h0E0, 8'h00);
      cmp_reg(rd, 8'h00);
    end
    cmp_bit(irq_n, 1'b1);
    $display("reset test done");
    for (int t = 0; t < 32; t++)
    begin
      {ex[t], st[t], pv[t]} = {t % 7 != 0, 8'h00};
      if (t != 0)
        ind(1'b0, 7'(t), {3'h0, ex[t], 4'h0});
    end
    ind(1'b1, 7'h10, 8'h00);
    cmp_reg(rd, 8'h00);
    $display("indirect test done");
    foreach (ph[p])
    begin
      cfg = ph[p][7:0];
      bus(1'b1, `E1RCB_IDX_CONFIG, cfg);
      alarm_in <= ph[p][10:8];
      for (int i = 0; i < 8; i++)
      begin
        // equal pairs let debounce pass on the second codeword
        if (!i[0])
          {fr, oc} = 12'($random(seed));
        inject(fr, oc);
      end
      alarm_in <= '0;
      check_all();
      $display("signaling phase %0d done", p);
    end
    ce <= 1'b0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    bus(1'b1, `E1RCB_IDX_CONFIG, 8'h00);
    bus(1'b1, `E1RCB_IDX_INT_MASK, 8'h02);
    bus(1'b0, `E1RCB_IDX_INT_STAT, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      alarm_in <= 3'b001;
      @(posedge hclk);
      alarm_in <= 3'b000;
      repeat (3) @(posedge hclk);
      cmp_bit(irq_n, 1'(m));
      bus(1'b0, `E1RCB_IDX_INT_STAT, 8'h00);
      cmp_reg(rd, 8'h02);
      repeat (2) @(posedge hclk);
      cmp_bit(irq_n, 1'b1);
      bus(1'b1, `E1RCB_IDX_INT_MASK, 8'h00);
    end
    $display("interrupt test done");
    summarize();
  end
endmodule
